/* File: core/mil_pkg.sv */
package mil_pkg;
    // =====================================================================
    // Register indices on the plain register port
    // =====================================================================
    localparam logic [1:0] ADDR_INTERRUPT_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_PERIPHERAL_FLAGS  = 2'h1;
    localparam logic [1:0] ADDR_PERIPHERAL_ENABLE = 2'h2;
    localparam logic [1:0] ADDR_OPTION            = 2'h3;

    // =====================================================================
    // Interrupt control field positions
    // =====================================================================
    localparam int BIT_GLOBAL_EN   = 7;
    localparam int BIT_PERIPH_EN   = 6;
    localparam int BIT_TIMER_EN    = 5;
    localparam int BIT_EXT_EN      = 4;
    localparam int BIT_PORT_EN     = 3;
    localparam int BIT_TIMER_FLAG  = 2;
    localparam int BIT_EXT_FLAG    = 1;
    localparam int BIT_PORT_FLAG   = 0;
    // Peripheral flag / enable registers: converter bit
    localparam int BIT_CONV        = 6;
    // Option register: edge select
    localparam int BIT_EDGE_SEL    = 6;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIPHERAL        = 8'h00;
    localparam logic [7:0] RST_OPTION            = 8'hFF;

    // =====================================================================
    // Vector, timer wrap, port pin and quarter phase counts
    // =====================================================================
    localparam logic [12:0] IRQ_VECTOR     = 13'h0004;
    localparam logic [7:0]  TIMER_MAX      = 8'hFF;
    localparam int          PORT_PINS      = 3;
    localparam logic [1:0]  PHASE_Q1       = 2'h0;
    localparam logic [1:0]  PHASE_Q4       = 2'h3;
endpackage : mil_pkg

/* File: core/mil_edge_detect.sv */
// Registers a pin and flags a change or a selected edge in the same cycle, against the registered level.
module mil_edge_detect
    import mil_pkg::*;
(
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic srst_i,
    // Pin and edge selection
    input  wire logic pin_i,
    input  wire logic rise_sel_i,
    // Detected events
    output logic      change_o,
    output logic      edge_o
);
    logic last_level;

    // =====================================================================
    // Previous level
    // =====================================================================
    // Pin is taken as synchronous, so one register gives the last level
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            last_level <= pin_i;            // Track the pin in reset too
        end else begin
            last_level <= pin_i;
        end
    end

    // Level follows the pin through reset, so a pin idling high gives no false edge on release
    assign change_o = pin_i ^ last_level;
    assign edge_o   = rise_sel_i ? (pin_i & ~last_level) : (~pin_i & last_level);
endmodule : mil_edge_detect

/* File: core/mil_interrupt_logic.sv */
// Strobed register access and the register offsets were chosen for this implementation.
module mil_interrupt_logic
    import mil_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    // Register port
    input  wire logic [1:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // Quarter phase of the instruction cycle
    input  wire logic [1:0]  phase_i,
    // Event sources
    input  wire logic        timer_tick_i,
    input  wire logic [7:0]  timer_count_i,
    input  wire logic        ext_irq_pin_i,
    input  wire logic        port_pin0_i,
    input  wire logic        port_pin1_i,
    input  wire logic        port_pin3_i,
    input  wire logic        converter_done_i,
    // Core sequencer
    input  wire logic [12:0] pc_next_i,
    input  wire logic        return_from_irq_instr_i,
    input  wire logic        sleeping_i,
    input  wire logic        irq_ack_i,
    output logic             irq_request_o,
    output logic             wake_o,
    output logic             wake_vector_o,
    output logic             stack_push_o,
    output logic      [12:0] stack_data_o,
    output logic      [12:0] pc_load_value_o,
    output logic             pc_load_o
);
    // =====================================================================
    // Registers and state
    // =====================================================================
    typedef enum logic [2:0] {
        MIL_RUN    = 3'b001,
        MIL_WAIT   = 3'b010,
        MIL_ENTRY  = 3'b100
    } mil_state_t;

    mil_state_t state;
    mil_state_t next_state;

    logic [7:0] interrupt_control;
    logic [7:0] peripheral_flags;
    logic [7:0] peripheral_enables;
    logic [7:0] option_reg;
    logic       ext_pending;      // Edge caught, waiting for the next Q4 or Q1
    logic [7:0] next_control;

    // =====================================================================
    // Event detection
    // =====================================================================
    wire logic [PORT_PINS-1:0] port_pins;
    wire logic [PORT_PINS-1:0] port_change;
    wire logic                 ext_edge;
    wire logic                 timer_wrap;
    wire logic                 port_event;

    assign port_pins = {port_pin3_i, port_pin1_i, port_pin0_i};

    // Pin edge detector, polarity from the option register
    mil_edge_detect u_ext_edge (
        .clock_i    (clock_i),
        .srst_i     (srst_i),
        .pin_i      (ext_irq_pin_i),
        .rise_sel_i (option_reg[BIT_EDGE_SEL]),
        .change_o   (),
        .edge_o     (ext_edge)
    );

    // One change detector per monitored port pin
    genvar gi;
    generate
        for (gi = 0; gi < PORT_PINS; gi++) begin : g_port
            mil_edge_detect u_port (
                .clock_i    (clock_i),
                .srst_i     (srst_i),
                .pin_i      (port_pins[gi]),
                .rise_sel_i (1'b1),
                .change_o   (port_change[gi]),
                .edge_o     ()
            );
        end
    endgenerate

    assign port_event = |port_change;
    assign timer_wrap = timer_tick_i && (timer_count_i == TIMER_MAX);

    // Pin flag may only land in Q4..Q1; an edge elsewhere waits
    wire logic ext_window  = (phase_i == PHASE_Q4) || (phase_i == PHASE_Q1);
    wire logic ext_set     = (ext_edge || ext_pending) && ext_window;

    // =====================================================================
    // Request combination
    // =====================================================================
    wire logic conv_active = peripheral_flags[BIT_CONV] & peripheral_enables[BIT_CONV]
                             & interrupt_control[BIT_PERIPH_EN];
    wire logic any_active  = (interrupt_control[BIT_TIMER_FLAG] & interrupt_control[BIT_TIMER_EN])
                           | (interrupt_control[BIT_EXT_FLAG]   & interrupt_control[BIT_EXT_EN])
                           | (interrupt_control[BIT_PORT_FLAG]  & interrupt_control[BIT_PORT_EN])
                           | conv_active;
    wire logic global_en   = interrupt_control[BIT_GLOBAL_EN];
    // Request sampled at Q1 only, which gives the one to four cycle latency
    wire logic q1          = (phase_i == PHASE_Q1);
    wire logic take_irq    = global_en && any_active && q1 && (state == MIL_RUN);

    assign irq_request_o = global_en && any_active;
    assign wake_o        = sleeping_i && any_active;
    assign wake_vector_o = wake_o && global_en;

    // =====================================================================
    // Write decode
    // =====================================================================
    wire logic wr_control = reg_wr_i && (reg_addr_i == ADDR_INTERRUPT_CONTROL);
    wire logic wr_pflags  = reg_wr_i && (reg_addr_i == ADDR_PERIPHERAL_FLAGS);
    wire logic wr_penable = reg_wr_i && (reg_addr_i == ADDR_PERIPHERAL_ENABLE);
    wire logic wr_option  = reg_wr_i && (reg_addr_i == ADDR_OPTION);

    // Control register next value: software write first, hardware sets win
    always_comb begin
        next_control = wr_control ? reg_wdata_i : interrupt_control;
        // Flags are only ever set here; clearing is software's job
        if (timer_wrap) begin
            next_control[BIT_TIMER_FLAG] = 1'b1;
        end
        if (ext_set) begin
            next_control[BIT_EXT_FLAG] = 1'b1;
        end
        if (port_event) begin
            next_control[BIT_PORT_FLAG] = 1'b1;
        end
        if (take_irq) begin
            next_control[BIT_GLOBAL_EN] = 1'b0;
        end else if (return_from_irq_instr_i) begin
            next_control[BIT_GLOBAL_EN] = 1'b1;
        end
    end

    // =====================================================================
    // Register storage
    // =====================================================================
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            interrupt_control <= RST_INTERRUPT_CONTROL;
        end else begin
            interrupt_control <= next_control;
        end
    end

    // Converter flag set wins over a software clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            peripheral_flags <= RST_PERIPHERAL;
        end else begin
            if (wr_pflags) begin
                peripheral_flags <= reg_wdata_i & (8'h01 << BIT_CONV);
            end
            if (converter_done_i) begin
                peripheral_flags[BIT_CONV] <= 1'b1;
            end
        end
    end

    // Peripheral enables and option register
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            peripheral_enables <= RST_PERIPHERAL;
            option_reg         <= RST_OPTION;
        end else begin
            if (wr_penable) begin
                peripheral_enables <= reg_wdata_i & (8'h01 << BIT_CONV);
            end
            if (wr_option) begin
                option_reg <= reg_wdata_i;
            end
        end
    end

    // Edge outside the Q4..Q1 window is held until the window opens
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ext_pending <= 1'b0;
        end else begin
            ext_pending <= (ext_edge || ext_pending) && !ext_window;
        end
    end

    // =====================================================================
    // Read port
    // =====================================================================
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_INTERRUPT_CONTROL: reg_rdata_o <= interrupt_control;
                ADDR_PERIPHERAL_FLAGS:  reg_rdata_o <= peripheral_flags;
                ADDR_PERIPHERAL_ENABLE: reg_rdata_o <= peripheral_enables;
                ADDR_OPTION:            reg_rdata_o <= option_reg;
                default:                reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // =====================================================================
    // Entry sequencer
    // =====================================================================
    // The core finishes its current instruction, then acks; push and
    // vector load are one-cycle pulses after that
    always_comb begin
        case (state)
            MIL_RUN:   next_state = take_irq ? MIL_WAIT : MIL_RUN;
            MIL_WAIT:  next_state = irq_ack_i ? MIL_ENTRY : MIL_WAIT;
            MIL_ENTRY: next_state = MIL_RUN;
            default:   next_state = MIL_RUN;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state <= MIL_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Only the return address is saved; W and status are left to software
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            stack_push_o    <= 1'b0;
            stack_data_o    <= 13'h0000;
            pc_load_o       <= 1'b0;
            pc_load_value_o <= 13'h0000;
        end else begin
            stack_push_o    <= (state == MIL_WAIT) && irq_ack_i;
            pc_load_o       <= (state == MIL_WAIT) && irq_ack_i;
            if ((state == MIL_WAIT) && irq_ack_i) begin
                stack_data_o    <= pc_next_i;
                pc_load_value_o <= IRQ_VECTOR;
            end
        end
    end
endmodule : mil_interrupt_logic

/* File: verification/mil_interrupt_logic_monitor.sv */
// =============================================
// Port checker for the interrupt logic
module mil_interrupt_logic_monitor
    import mil_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    // Register port
    input  wire logic [1:0]  reg_addr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_rdata_o,
    // Sources and phase
    input  wire logic [1:0]  phase_i,
    input  wire logic        timer_tick_i,
    input  wire logic [7:0]  timer_count_i,
    // Core side
    input  wire logic [12:0] pc_next_i,
    input  wire logic        sleeping_i,
    input  wire logic        irq_ack_i,
    input  wire logic        irq_request_o,
    input  wire logic        wake_o,
    input  wire logic        wake_vector_o,
    input  wire logic        stack_push_o,
    input  wire logic [12:0] stack_data_o,
    input  wire logic [12:0] pc_load_value_o,
    input  wire logic        pc_load_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    chk_vector_load: assert property (pc_load_o |-> pc_load_value_o == IRQ_VECTOR && stack_push_o)
        else $error("vector load wrong");
    chk_push_after_ack: assert property (stack_push_o |-> $past(irq_ack_i))
        else $error("push without ack");
    chk_ack_to_push: assert property (irq_ack_i |=> stack_push_o)
        else $error("ack not followed by push");
    chk_push_data: assert property (stack_push_o |-> stack_data_o == $past(pc_next_i))
        else $error("pushed address wrong");
    chk_push_single: assert property (stack_push_o |=> !stack_push_o)
        else $error("push longer than one cycle");
    chk_take_clears: assert property (irq_request_o && phase_i == PHASE_Q1 |=> !irq_request_o)
        else $error("global enable kept after take");
    chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside read slot");
    chk_timer_flag: assert property (timer_tick_i && timer_count_i == TIMER_MAX ##[1:3]
        reg_rd_i && reg_addr_i == ADDR_INTERRUPT_CONTROL |=> reg_rdata_o[BIT_TIMER_FLAG])
        else $error("timer wrap flag missing");
    chk_wake_vector: assert property (sleeping_i |-> wake_vector_o == irq_request_o)
        else $error("wake vector mismatch");
    chk_wake_awake: assert property (!sleeping_i |-> !wake_o && !wake_vector_o)
        else $error("wake while running");

    // Main scenarios seen
    cover property (stack_push_o);
    cover property (wake_o && !wake_vector_o);
    cover property (reg_rd_i ##1 reg_rdata_o != 8'h00);
endmodule : mil_interrupt_logic_monitor

/* File: verification/mil_core_model.sv */
// =============================================
// Core sequencer: phases, fetch address, entry ack
module mil_core_model
    import mil_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    // Control from the bench and the interrupt logic
    input  wire logic [1:0]  ack_wait_i,
    input  wire logic        irq_request_i,
    // Towards the interrupt logic
    output logic      [1:0]  phase_o,
    output logic      [12:0] pc_o,
    output logic             ack_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       pending;
    logic [1:0] wait_cnt;

    // Ack can be held back to act as a slow core
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            phase_o  <= PHASE_Q1;
            pc_o     <= 13'h0100;
            pending  <= 1'b0;
            wait_cnt <= 2'h0;
            ack_o    <= 1'b0;
        end else begin
            phase_o <= phase_o + 2'h1;
            pc_o    <= pc_o + 13'h0001;
            ack_o   <= 1'b0;
            if (irq_request_i && phase_o == PHASE_Q1 && !pending) begin
                pending  <= 1'b1;
                wait_cnt <= ack_wait_i;
            end else if (pending && wait_cnt != 2'h0) begin
                wait_cnt <= wait_cnt - 2'h1;
            end else if (pending) begin
                pending <= 1'b0;
                ack_o   <= 1'b1;
            end
        end
    end
endmodule : mil_core_model

/* File: verification/mil_interrupt_logic_test.sv */
// =============================================
// Self-checking bench for the interrupt logic
module mil_interrupt_logic_test;
    timeunit 1ns;
    timeprecision 1ns;
    import mil_pkg::*;
    logic        clock_i, srst_i, reg_wr_i, reg_rd_i, timer_tick_i, ext_pin, conv_done, ret_pulse, sleeping;
    logic [1:0]  reg_addr_i, phase, ack_wait;
    logic [7:0]  reg_wdata_i, reg_rdata_o, timer_count_i;
    logic [2:0]  pins;
    logic [12:0] pc_next, stack_data_o, pc_load_value_o, ack_pc;
    logic        irq_ack, irq_request_o, wake_o, wake_vector_o, stack_push_o, pc_load_o;
    int          fails, compares;

    mil_interrupt_logic dut (.clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .phase_i(phase), .timer_tick_i(timer_tick_i), .timer_count_i(timer_count_i), .ext_irq_pin_i(ext_pin),
        .port_pin0_i(pins[0]), .port_pin1_i(pins[1]), .port_pin3_i(pins[2]), .converter_done_i(conv_done),
        .pc_next_i(pc_next), .return_from_irq_instr_i(ret_pulse), .sleeping_i(sleeping), .irq_ack_i(irq_ack),
        .irq_request_o(irq_request_o), .wake_o(wake_o), .wake_vector_o(wake_vector_o),
        .stack_push_o(stack_push_o), .stack_data_o(stack_data_o), .pc_load_value_o(pc_load_value_o),
        .pc_load_o(pc_load_o));
    mil_core_model core (.clock_i(clock_i), .srst_i(srst_i), .ack_wait_i(ack_wait),
        .irq_request_i(irq_request_o), .phase_o(phase), .pc_o(pc_next), .ack_o(irq_ack));

    task automatic check(input logic [12:0] got, input logic [12:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Register port master: one-cycle strobes
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clock_i);
        {reg_rd_i, reg_addr_i} <= {1'b1, a};
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        @(negedge clock_i);
        check({5'h00, reg_rdata_o}, {5'h00, e});
    endtask : rd
    task automatic t_reset;
        rd(ADDR_INTERRUPT_CONTROL, 8'h00);
        rd(ADDR_PERIPHERAL_FLAGS, 8'h00);
        rd(ADDR_OPTION, 8'hFF);
        wr(ADDR_PERIPHERAL_ENABLE, 8'hFF);
        rd(ADDR_PERIPHERAL_ENABLE, 8'h40);
        wr(ADDR_PERIPHERAL_ENABLE, 8'h00);
    endtask : t_reset
    task automatic t_timer;
        for (int i = 0; i < 2; i++) begin
            @(posedge clock_i);
            {timer_tick_i, timer_count_i} <= {1'b1, 8'hFE + 8'(i)};
            @(posedge clock_i);
            timer_tick_i <= 1'b0;
            rd(ADDR_INTERRUPT_CONTROL, i == 1 ? 8'h04 : 8'h00);
            check({12'h000, irq_request_o}, 13'h0000);
        end
        wr(ADDR_INTERRUPT_CONTROL, 8'h00);
    endtask : t_timer
    task automatic t_port;
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_INTERRUPT_CONTROL, 8'h00);
            pins[i] <= 1'b1;
            repeat (3) @(posedge clock_i);
            rd(ADDR_INTERRUPT_CONTROL, 8'h01);
        end
    endtask : t_port
    // Edge select both ways, wrong edge must not flag
    task automatic t_edge;
        logic [7:0] opt [4] = '{8'hFF, 8'h00, 8'h00, 8'hFF};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_OPTION, opt[i]);
            wr(ADDR_INTERRUPT_CONTROL, 8'h00);
            ext_pin <= (i % 2 == 0);
            repeat (8) @(posedge clock_i);
            rd(ADDR_INTERRUPT_CONTROL, i < 2 ? 8'h02 : 8'h00);
        end
    endtask : t_edge
    // Enables seen through wake while the global enable is clear
    task automatic t_gate;
        logic [7:0] ctl [8] = '{8'h04, 8'h24, 8'h02, 8'h12, 8'h01, 8'h09, 8'h00, 8'h40};
        @(posedge clock_i);
        sleeping  <= 1'b1;
        conv_done <= 1'b1;
        @(posedge clock_i);
        conv_done <= 1'b0;
        rd(ADDR_PERIPHERAL_FLAGS, 8'h40);
        wr(ADDR_PERIPHERAL_ENABLE, 8'h40);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_INTERRUPT_CONTROL, ctl[i]);
            @(negedge clock_i);
            check({12'h000, wake_o}, 13'(i % 2));
            check({12'h000, wake_vector_o}, 13'h0000);
        end
        // Global enable set while asleep: the wake must ask for the vector, then the entry runs out
        wr(ADDR_INTERRUPT_CONTROL, 8'hC0);
        @(negedge clock_i);
        check({12'h000, wake_vector_o}, 13'h0001);
        repeat (8) @(posedge clock_i);
        wr(ADDR_PERIPHERAL_FLAGS, 8'h00);
        wr(ADDR_INTERRUPT_CONTROL, 8'h00);
        sleeping <= 1'b0;
    endtask : t_gate
    task automatic t_take(input logic [1:0] w);
        int n;
        ack_wait <= w;
        wr(ADDR_INTERRUPT_CONTROL, 8'h90);
        ext_pin <= 1'b1;
        n = 0;
        while (stack_push_o !== 1'b1 && n < 40) begin
            @(negedge clock_i);
            if (irq_ack === 1'b1) ack_pc = pc_next;
            n++;
        end
        check({12'h000, (n - int'(w)) <= 16}, 13'h0001);
        check({12'h000, pc_load_o}, 13'h0001);
        check(pc_load_value_o, 13'h0004);
        check(stack_data_o, ack_pc);
        rd(ADDR_INTERRUPT_CONTROL, 8'h12);
        wr(ADDR_INTERRUPT_CONTROL, 8'h10);
        @(posedge clock_i);
        ret_pulse <= 1'b1;
        @(posedge clock_i);
        ret_pulse <= 1'b0;
        rd(ADDR_INTERRUPT_CONTROL, 8'h90);
        // Reset in mid-run with the global enable set and the pins high: no false events after it
        @(posedge clock_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        srst_i <= 1'b0;
        rd(ADDR_INTERRUPT_CONTROL, 8'h00);
        wr(ADDR_INTERRUPT_CONTROL, 8'h00);
        ext_pin <= 1'b0;
        repeat (8) @(posedge clock_i);
    endtask : t_take
    task automatic final_report;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // Clock, then reset and the scenarios in order
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    initial begin
        {reg_wr_i, reg_rd_i, timer_tick_i, ext_pin, conv_done, ret_pulse, sleeping, pins} = '0;
        {reg_addr_i, reg_wdata_i, timer_count_i, ack_wait, fails, compares} = '0;
        srst_i = 1'b1;
        repeat (5) @(posedge clock_i);
        srst_i <= 1'b0;
        t_reset();
        t_timer();
        t_port();
        t_edge();
        t_gate();
        t_take(2'h0);
        t_take(2'h2);
        final_report();
    end
    // Whole run is a few hundred cycles; this catches a hang
    initial begin
        #100000;
        fails++;
        final_report();
    end
endmodule : mil_interrupt_logic_test

bind mil_interrupt_logic mil_interrupt_logic_monitor u_mon (.clock_i(clock_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .phase_i(phase_i),
    .timer_tick_i(timer_tick_i), .timer_count_i(timer_count_i), .pc_next_i(pc_next_i), .sleeping_i(sleeping_i),
    .irq_ack_i(irq_ack_i), .irq_request_o(irq_request_o), .wake_o(wake_o), .wake_vector_o(wake_vector_o),
    .stack_push_o(stack_push_o), .stack_data_o(stack_data_o), .pc_load_value_o(pc_load_value_o),
    .pc_load_o(pc_load_o));
